// ==== psr_regs.svh ====
// register offsets, field positions and reset values of the peripheral soft reset block
// assumes byte addressing with one aligned 32-bit word per register
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PSR_OFS_GROUP0      12'h040
`define PSR_OFS_GROUP1      12'h044
`define PSR_OFS_CAP_A       12'h010
`define PSR_OFS_CAP_B       12'h014

// ****************************************************************
// reset values
// ****************************************************************
`define PSR_RST_GROUP       32'h0000_0000
`define PSR_RST_RDATA       32'h0000_0000

// ****************************************************************
// group0 fields
// ****************************************************************
`define PSR_G0_CONV0        16
`define PSR_G0_SLEEP        6
`define PSR_G0_WDOG         3
`define PSR_G0_DEFINED      32'h0001_0048

// ****************************************************************
// group1 fields
// ****************************************************************
`define PSR_G1_CMP_HI       26
`define PSR_G1_CMP_LO       24
`define PSR_G1_GPC_HI       19
`define PSR_G1_GPC_LO       16
`define PSR_G1_I2C0         12
`define PSR_G1_SSER0        4
`define PSR_G1_ASER_HI      2
`define PSR_G1_ASER_LO      0
`define PSR_G1_DEFINED      32'h070f_1017

// ****************************************************************
// reset output vector layout
// ****************************************************************
`define PSR_NUM_RESETS      15

`endif

// ==== psr_pkg.sv ====
// types and shared helpers of the peripheral soft reset block
// assumes psr_regs.svh is on the include path
`include "psr_regs.svh"

package psr_pkg;

	// register selected by the current bus address
	typedef enum logic [2:0]
	{
		PSR_SEL_NONE,
		PSR_SEL_GROUP0,
		PSR_SEL_GROUP1,
		PSR_SEL_CAP_A,
		PSR_SEL_CAP_B
	} psr_sel_t;

	// address decode, shared by the write and read paths
	function automatic psr_sel_t psr_decode(input logic [11:0] addr);
		psr_sel_t sel;
		sel = PSR_SEL_NONE;
		unique case (addr)
			`PSR_OFS_GROUP0: sel = PSR_SEL_GROUP0;
			`PSR_OFS_GROUP1: sel = PSR_SEL_GROUP1;
			`PSR_OFS_CAP_A:  sel = PSR_SEL_CAP_A;
			`PSR_OFS_CAP_B:  sel = PSR_SEL_CAP_B;
			default:         sel = PSR_SEL_NONE;
		endcase
		return sel;
	endfunction

	// only bits that exist and that the register defines may hold a one
	function automatic logic [31:0] psr_masked(
		input logic [31:0] value,
		input logic [31:0] cap,
		input logic [31:0] defined);
		return value & cap & defined;
	endfunction

endpackage

// ==== psr_masked_reg.sv ====
// one software reset register whose writes are masked by a capability word
// assumes a synchronous active-low reset and a single-cycle write strobe
`timescale 1ns/1ns
`default_nettype none
`include "psr_regs.svh"

module psr_masked_reg #(
	parameter logic [31:0] DEFINED = 32'hffff_ffff	// bits that the register implements
) (
	input  wire logic        clk,	// system clock
	input  wire logic        rstn,	// synchronous reset, active low
	input  wire logic        wr,	// write strobe for this register
	input  wire logic [31:0] wdata,	// write data
	input  wire logic [31:0] cap,	// capability word, one per present peripheral
	output logic      [31:0] q	// stored value
);

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [31:0] next_q;	// value after this edge

	// the capability mask is applied on every cycle, not just on writes,
	// so a peripheral that drops out can never stay stuck in reset
	assign next_q = psr_pkg::psr_masked(wr ? wdata : q, cap, DEFINED);

	// register with reset to all zeros
	always_ff @(posedge clk)
	begin
		if (!rstn)
			q <= `PSR_RST_GROUP;
		else
			q <= next_q;
	end

endmodule
`default_nettype wire

// ==== psr_reset_drive.sv ====
// output stage that holds each peripheral reset line in a flip-flop
// assumes the peripherals sample their reset on the same clock
`timescale 1ns/1ns
`default_nettype none

module psr_reset_drive #(
	parameter int W = 15	// number of reset lines
) (
	input  wire logic         clk,	// system clock
	input  wire logic         rstn,	// synchronous reset, active low
	input  wire logic [W-1:0] level,	// requested reset levels
	output logic      [W-1:0] hold	// registered reset lines, high = held
);

	// ****************************************************************
	// registered drive
	// ****************************************************************
	// a flop here keeps decode glitches off the peripheral reset nets;
	// the cost is one cycle of delay after each register write
	always_ff @(posedge clk)
	begin
		if (!rstn)
			hold <= '0;
		else
			hold <= level;
	end

endmodule
`default_nettype wire

// ==== psr_top.sv ====
// peripheral soft reset control: two masked reset registers and their reset lines
// assumes a plain register port with read data one cycle after the read strobe,
// and capability words that are synchronous to clk
//
// How it works
// - group0 writes masked by capability word a
// - group1 writes masked by capability word b
// - both registers 32 bits, reset zero
// - group0 bit 16 resets converter zero
// - group0 bit 6 resets sleep domain
// - group0 bit 3 resets watchdog
// - group1 bits 26..24 reset comparators two..zero
// - group1 bits 19..16 reset counters three..zero
// - group1 bit 12 resets i2c zero
// - group1 bit 4 resets sync serial zero
// - group1 bits 2..0 reset async serial two..zero
// - unassigned bits read only, read zero
`timescale 1ns/1ns
`default_nettype none
`include "psr_regs.svh"

module psr_top #(
	parameter int AW = 12	// register address width
) (
	input  wire logic          clk,			// system clock, 100 MHz
	input  wire logic          rstn,			// synchronous reset, active low
	input  wire logic [AW-1:0] addr,			// register byte address
	input  wire logic [31:0]   wdata,			// write data
	input  wire logic          wr_en,			// write strobe
	input  wire logic          rd_en,			// read strobe
	output logic      [31:0]   rdata,			// read data, cycle after rd_en
	input  wire logic [31:0]   capability_mask_a,		// present peripherals, group0
	input  wire logic [31:0]   capability_mask_b,		// present peripherals, group1
	output logic               converter_zero_reset,	// converter 0 held in reset
	output logic               sleep_domain_reset,		// sleep domain held in reset
	output logic               watchdog_reset,		// watchdog held in reset
	output logic               analog_cmp_zero_reset,	// comparator 0 held in reset
	output logic               analog_cmp_one_reset,	// comparator 1 held in reset
	output logic               analog_cmp_two_reset,	// comparator 2 held in reset
	output logic               gp_counter_zero_reset,	// counter 0 held in reset
	output logic               gp_counter_one_reset,	// counter 1 held in reset
	output logic               gp_counter_two_reset,	// counter 2 held in reset
	output logic               gp_counter_three_reset,	// counter 3 held in reset
	output logic               i2c_zero_reset,		// i2c 0 held in reset
	output logic               sync_serial_zero_reset,	// sync serial 0 held in reset
	output logic               async_serial_zero_reset,	// async serial 0 held in reset
	output logic               async_serial_one_reset,	// async serial 1 held in reset
	output logic               async_serial_two_reset	// async serial 2 held in reset
);

	// ****************************************************************
	// address decode
	// ****************************************************************
	psr_pkg::psr_sel_t sel;		// register under the address
	logic              wr_group0;	// write to group0
	logic              wr_group1;	// write to group1
	logic [11:0]       addr12;	// address at decode width

	// the upper address bits beyond the map are ignored by the compare width
	assign addr12    = addr[11:0];
	assign sel       = psr_pkg::psr_decode(addr12);
	assign wr_group0 = wr_en && (sel == psr_pkg::PSR_SEL_GROUP0);
	assign wr_group1 = wr_en && (sel == psr_pkg::PSR_SEL_GROUP1);

	// ****************************************************************
	// reset registers
	// ****************************************************************
	logic [31:0] group0;	// peripheral_reset_group0 contents
	logic [31:0] group1;	// peripheral_reset_group1 contents

	// group0, masked by capability word a
	psr_masked_reg #(
		.DEFINED (`PSR_G0_DEFINED)
	) u_group0 (
		.clk   (clk),
		.rstn  (rstn),
		.wr    (wr_group0),
		.wdata (wdata),
		.cap   (capability_mask_a),
		.q     (group0)
	);

	// group1, masked by capability word b
	psr_masked_reg #(
		.DEFINED (`PSR_G1_DEFINED)
	) u_group1 (
		.clk   (clk),
		.rstn  (rstn),
		.wr    (wr_group1),
		.wdata (wdata),
		.cap   (capability_mask_b),
		.q     (group1)
	);

	// ****************************************************************
	// read path
	// ****************************************************************
	logic [31:0] rd_value;		// word under the address
	logic [31:0] next_rdata;	// read data for the next cycle

	// unmapped addresses and reserved bits of group0 and group1 read zero; capability words read unmasked; reserved bits never
	// store a one, so no extra masking is needed here
	assign rd_value = (sel == psr_pkg::PSR_SEL_GROUP0) ? group0 :
	                  (sel == psr_pkg::PSR_SEL_GROUP1) ? group1 :
	                  (sel == psr_pkg::PSR_SEL_CAP_A)  ? capability_mask_a :
	                  (sel == psr_pkg::PSR_SEL_CAP_B)  ? capability_mask_b :
	                  `PSR_RST_RDATA;

	// read data stand for one cycle after each cycle of rd_en, then return to zero
	assign next_rdata = rd_en ? rd_value : `PSR_RST_RDATA;

	// read data register
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rdata <= `PSR_RST_RDATA;
		else
			rdata <= next_rdata;
	end

	// ****************************************************************
	// reset lines
	// ****************************************************************
	logic [`PSR_NUM_RESETS-1:0] level;	// requested reset levels
	logic [`PSR_NUM_RESETS-1:0] hold;	// registered reset lines

	// gather the defined bits into one vector, most significant first
	assign level = {
		group0[`PSR_G0_CONV0],
		group0[`PSR_G0_SLEEP],
		group0[`PSR_G0_WDOG],
		group1[`PSR_G1_CMP_HI:`PSR_G1_CMP_LO],
		group1[`PSR_G1_GPC_HI:`PSR_G1_GPC_LO],
		group1[`PSR_G1_I2C0],
		group1[`PSR_G1_SSER0],
		group1[`PSR_G1_ASER_HI:`PSR_G1_ASER_LO]
	};

	// each line stays high while its bit is set
	psr_reset_drive #(
		.W (`PSR_NUM_RESETS)
	) u_drive (
		.clk   (clk),
		.rstn  (rstn),
		.level (level),
		.hold  (hold)
	);

	// fan the registered vector out to the named lines
	// the vector holds exactly the fifteen defined bits, no padding
	assign converter_zero_reset    = hold[14];
	assign sleep_domain_reset      = hold[13];
	assign watchdog_reset          = hold[12];
	assign analog_cmp_two_reset    = hold[11];
	assign analog_cmp_one_reset    = hold[10];
	assign analog_cmp_zero_reset   = hold[9];
	assign gp_counter_three_reset  = hold[8];
	assign gp_counter_two_reset    = hold[7];
	assign gp_counter_one_reset    = hold[6];
	assign gp_counter_zero_reset   = hold[5];
	assign i2c_zero_reset          = hold[4];
	assign sync_serial_zero_reset  = hold[3];
	assign async_serial_two_reset  = hold[2];
	assign async_serial_one_reset  = hold[1];
	assign async_serial_zero_reset = hold[0];

	// ****************************************************************
	// checks
	// ****************************************************************
	// a write lands masked by the capability word of its cycle
	property p_group0_mask;
		@(posedge clk) disable iff (!rstn)
		wr_group0 |=> group0 == ($past(wdata) & $past(capability_mask_a)
		                         & `PSR_G0_DEFINED);
	endproperty
	a_group0_mask: assert property (p_group0_mask)
		else $error("group0 write not masked by capability a");

	// same for group1
	property p_group1_mask;
		@(posedge clk) disable iff (!rstn)
		wr_group1 |=> group1 == ($past(wdata) & $past(capability_mask_b)
		                         & `PSR_G1_DEFINED);
	endproperty
	a_group1_mask: assert property (p_group1_mask)
		else $error("group1 write not masked by capability b");

	// after reset release both registers and all lines start at zero
	property p_reset_zero;
		@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> (group0 == `PSR_RST_GROUP) && (group1 == `PSR_RST_GROUP)
		                && (hold == '0) && (rdata == `PSR_RST_RDATA);
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("registers not zero after reset");

	// converter line follows its bit one cycle later
	property p_conv_line;
		@(posedge clk) disable iff (!rstn)
		$rose(group0[`PSR_G0_CONV0]) |=> converter_zero_reset;
	endproperty
	a_conv_line: assert property (p_conv_line)
		else $error("converter reset line does not follow its bit");

	// sleep domain line tracks its bit with one cycle delay
	property p_sleep_line;
		@(posedge clk) disable iff (!rstn)
		##1 sleep_domain_reset == $past(group0[`PSR_G0_SLEEP]);
	endproperty
	a_sleep_line: assert property (p_sleep_line)
		else $error("sleep domain reset line wrong");

	// watchdog line: a write that sets the bit raises the line two edges later
	property p_wdog_line;
		@(posedge clk) disable iff (!rstn)
		(wr_group0 && wdata[`PSR_G0_WDOG] && capability_mask_a[`PSR_G0_WDOG])
		##1 capability_mask_a[`PSR_G0_WDOG] |=> watchdog_reset;
	endproperty
	a_wdog_line: assert property (p_wdog_line)
		else $error("watchdog reset line not raised");

	// comparator lines follow bits 26..24
	property p_cmp_lines;
		@(posedge clk) disable iff (!rstn)
		##1 {analog_cmp_two_reset, analog_cmp_one_reset, analog_cmp_zero_reset}
		    == $past(group1[`PSR_G1_CMP_HI:`PSR_G1_CMP_LO]);
	endproperty
	a_cmp_lines: assert property (p_cmp_lines)
		else $error("comparator reset lines wrong");

	// counter lines follow bits 19..16
	property p_gpc_lines;
		@(posedge clk) disable iff (!rstn)
		##1 {gp_counter_three_reset, gp_counter_two_reset,
		     gp_counter_one_reset, gp_counter_zero_reset}
		    == $past(group1[`PSR_G1_GPC_HI:`PSR_G1_GPC_LO]);
	endproperty
	a_gpc_lines: assert property (p_gpc_lines)
		else $error("counter reset lines wrong");

	// i2c and sync serial lines follow bits 12 and 4
	property p_serial_lines;
		@(posedge clk) disable iff (!rstn)
		##1 (i2c_zero_reset == $past(group1[`PSR_G1_I2C0]))
		    && (sync_serial_zero_reset == $past(group1[`PSR_G1_SSER0]));
	endproperty
	a_serial_lines: assert property (p_serial_lines)
		else $error("i2c or sync serial reset line wrong");

	// async serial lines follow bits 2..0
	property p_aser_lines;
		@(posedge clk) disable iff (!rstn)
		##1 {async_serial_two_reset, async_serial_one_reset, async_serial_zero_reset}
		    == $past(group1[`PSR_G1_ASER_HI:`PSR_G1_ASER_LO]);
	endproperty
	a_aser_lines: assert property (p_aser_lines)
		else $error("async serial reset lines wrong");

	// reads of group0 never show unassigned bits
	property p_reserved_zero;
		@(posedge clk) disable iff (!rstn)
		rd_en && (sel == psr_pkg::PSR_SEL_GROUP0) |=>
		(rdata & ~`PSR_G0_DEFINED) == '0 && rdata == $past(group0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("group0 read shows reserved bits or wrong value");

	// the watchdog line stays high while group0 is not written and its capability bit stays set
	property p_hold_steady;
		@(posedge clk) disable iff (!rstn)
		(watchdog_reset && group0[`PSR_G0_WDOG] && !wr_group0
		 && capability_mask_a[`PSR_G0_WDOG])
		##1 capability_mask_a[`PSR_G0_WDOG] |=> watchdog_reset;
	endproperty
	a_hold_steady: assert property (p_hold_steady)
		else $error("reset line dropped without a clearing write");

	// bits of absent peripherals never read one
	property p_absent_zero;
		@(posedge clk) disable iff (!rstn)
		##1 ((group1 & ~$past(capability_mask_b)) == '0)
		    && ((group0 & ~$past(capability_mask_a)) == '0);
	endproperty
	a_absent_zero: assert property (p_absent_zero)
		else $error("bit of absent peripheral holds a one");

endmodule
`default_nettype wire

// ==== psr_top_bench.sv ====
// self-checking bench for the peripheral soft reset block
// assumes psr_top with its default address width and a 100 MHz clock
`timescale 1ns/1ns
`default_nettype none

module psr_top_bench;

	// ****************************************************************
	// bench signals
	// ****************************************************************
	localparam logic [31:0] DEF0 = 32'h0001_0048;	// implemented bits of group0
	localparam logic [31:0] DEF1 = 32'h070f_1017;	// implemented bits of group1

	typedef struct
	{
		logic [11:0] addr;	// register written
		logic [31:0] cap_a;	// presence word a
		logic [31:0] cap_b;	// presence word b
		logic [31:0] data;	// value written
		logic [31:0] exp;	// value that register should then read
	} psr_row_t;

	logic        clk;		// system clock
	logic        rstn;		// synchronous reset, active low
	logic [11:0] addr;		// bus address
	logic [31:0] wdata;		// bus write data
	logic        wr_en;		// write strobe
	logic        rd_en;		// read strobe
	wire  [31:0] rdata;		// bus read data
	logic [31:0] cap_a;		// presence bits, group0
	logic [31:0] cap_b;		// presence bits, group1
	wire  [16:0] seen;		// all reset lines, packed
	logic [31:0] m0;		// bench copy of group0
	logic [31:0] m1;		// bench copy of group1
	int          error_cnt;	// mismatches
	int          tests_run;	// comparisons
	psr_row_t    rows [9];	// ordinary cases

	// ****************************************************************
	// design under test
	// ****************************************************************
	psr_top i_dut
	(
		.clk                    (clk),
		.rstn                   (rstn),
		.addr                   (addr),
		.wdata                  (wdata),
		.wr_en                  (wr_en),
		.rd_en                  (rd_en),
		.rdata                  (rdata),
		.capability_mask_a      (cap_a),
		.capability_mask_b      (cap_b),
		.converter_zero_reset   (seen[16]),
		.sleep_domain_reset     (seen[15]),
		.watchdog_reset         (seen[14]),
		.analog_cmp_two_reset   (seen[13]),
		.analog_cmp_one_reset   (seen[12]),
		.analog_cmp_zero_reset  (seen[11]),
		.gp_counter_three_reset (seen[10]),
		.gp_counter_two_reset   (seen[9]),
		.gp_counter_one_reset   (seen[8]),
		.gp_counter_zero_reset  (seen[7]),
		.i2c_zero_reset         (seen[6]),
		.sync_serial_zero_reset (seen[5]),
		.async_serial_two_reset (seen[4]),
		.async_serial_one_reset (seen[3]),
		.async_serial_zero_reset(seen[2:2])
	);
	assign seen[1:0] = 2'h0;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// reset lines expected from the two register values, same order as seen
	function automatic logic [16:0] lines_of(input logic [31:0] a, input logic [31:0] b);
		return {a[16], a[6], a[3], b[26:24], b[19:16], b[12], b[4], b[2:0], 2'h0};
	endfunction

	// word compare, case equality so an unknown never matches
	task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// reset line compare
	task automatic chk_lines(input logic [16:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch reset_lines expected %h seen %h", exp, seen);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// read, data looked at in the one cycle that it stands
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk_word(nm, exp, rdata);
	endtask

	// presence words change; stored bits of absent units clear
	task automatic set_caps(input logic [31:0] a, input logic [31:0] b);
		@(posedge clk);
		cap_a <= a;
		cap_b <= b;
		m0 = m0 & a & DEF0;
		m1 = m1 & b & DEF1;
	endtask

	// both registers and all lines against the bench copy
	task automatic chk_all();
		rd(12'h040, m0, "group0");
		rd(12'h044, m1, "group1");
		chk_lines(lines_of(m0, m1));
	endtask

	// single place where the run ends
	task automatic test_done();
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************************************************************
	// clock and watchdog
	// ****************************************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// whole run needs well under 300 cycles; cut a hang at 3000
	initial
	begin
		#30000;
		error_cnt++;
		test_done();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		rstn      = 1'b0;
		addr      = 12'h000;
		wdata     = 32'h0000_0000;
		wr_en     = 1'b0;
		rd_en     = 1'b0;
		cap_a     = 32'hffff_ffff;
		cap_b     = 32'hffff_ffff;
		m0        = 32'h0000_0000;
		m1        = 32'h0000_0000;
		error_cnt = 0;
		tests_run = 0;
		rows = '{
			'{12'h040, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h0001_0048},
			'{12'h044, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h070f_1017},
			'{12'h040, 32'h0000_0008, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0008},
			'{12'h040, 32'h0001_0040, 32'hffff_ffff, 32'h0001_0048, 32'h0001_0040},
			'{12'h044, 32'h0001_0040, 32'h0700_0000, 32'hffff_ffff, 32'h0700_0000},
			'{12'h044, 32'h0001_0040, 32'h000f_0000, 32'h000a_0000, 32'h000a_0000},
			'{12'h044, 32'h0001_0040, 32'hffff_ffff, 32'h0000_1010, 32'h0000_1010},
			'{12'h044, 32'h0001_0040, 32'hffff_fffe, 32'h0000_0007, 32'h0000_0006},
			'{12'h040, 32'hffff_ffff, 32'hffff_fffe, 32'h0000_0000, 32'h0000_0000}
		};
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		chk_all();

		// ordinary cases: masked writes, field positions, release
		foreach (rows[i])
		begin
			set_caps(rows[i].cap_a, rows[i].cap_b);
			wr(rows[i].addr, rows[i].data);
			if (rows[i].addr == 12'h040)
				m0 = rows[i].exp;
			else
				m1 = rows[i].exp;
			chk_all();
		end

		// write then read with no gap between the strobes
		set_caps(32'hffff_ffff, 32'hffff_ffff);
		@(posedge clk);
		addr  <= 12'h040;
		wdata <= 32'hffff_fff7;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk_word("group0_back_to_back", 32'h0001_0040, rdata);
		m0 = 32'h0001_0040;

		// unmapped and read-only offsets take no write
		wr(12'h048, 32'hffff_ffff);
		wr(12'h010, 32'h0000_0000);
		rd(12'h048, 32'h0000_0000, "unmapped");
		rd(12'h010, 32'hffff_ffff, "capability_a");
		wr(12'h044, 32'h0000_0008);
		m1 = 32'h0000_0000;
		chk_all();

		// a unit that disappears drops its stored bit and its line
		wr(12'h044, 32'h0700_0000);
		m1 = 32'h0700_0000;
		chk_all();
		set_caps(32'hffff_ffff, 32'h0500_0000);
		chk_all();

		// reset again in mid-run clears registers and lines
		wr(12'h040, 32'h0001_0048);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk_lines(17'h0_0000);
		m0 = 32'h0000_0000;
		m1 = 32'h0000_0000;
		chk_all();
		test_done();
	end

endmodule
`default_nettype wire
